// >>> common/dfc_cfg.svh
`ifndef DFC_CFG_SVH
`define DFC_CFG_SVH

// Register port geometry
`define DFC_ADDR_W 16
`define DFC_DATA_W 16

// Register offsets
`define DFC_OFS_SLEEP 16'hF400
`define DFC_OFS_FSEL 16'hF401
`define DFC_OFS_STATUS 16'hF410
`define DFC_OFS_FCOUNT 16'hF411

// Field layout
`define DFC_BIT_SLEEP 0
`define DFC_SEL_W 5
`define DFC_FCOUNT_W 16

// Reset values
`define DFC_RST_SLEEP 1'b0
`define DFC_RST_FSEL 5'h02

// Status bits
`define DFC_ST_SLEEPING 0
`define DFC_ST_DRAIN 1
`define DFC_ST_WAKE 2
`define DFC_ST_OVERRUN 3
`define DFC_ST_BADSEL 4
`define DFC_ST_BUSY 5

// Frame pulse selector codes
`define DFC_SEL_G1_DIV4 5'h00
`define DFC_SEL_G1_X4 5'h04
`define DFC_SEL_G2_DIV6 5'h05
`define DFC_SEL_G2_X2D3 5'h07
`define DFC_SEL_SIN0 5'h08
`define DFC_SEL_SPDIF 5'h10

// Source and interrupt counts
`define DFC_NUM_G1 5
`define DFC_NUM_G2 3
`define DFC_NUM_SER 4
`define DFC_NUM_ASYNC 9
`define DFC_NUM_IRQ 8

`endif

// >>> common/dfc_pkg.sv
`include "dfc_cfg.svh"

package dfc_pkg;

	typedef enum logic [1:0] {
		ST_RUN,
		ST_DRAIN,
		ST_SLEEP,
		ST_WAKE
	} dfc_core_state_e;

	// Clock generator members are core-clock pulses; port and receiver members are raw frame clocks
	typedef struct packed {
		logic spdif;
		logic [`DFC_NUM_SER-1:0] ser_out;
		logic [`DFC_NUM_SER-1:0] ser_in;
		logic [`DFC_NUM_G2-1:0] gen2;
		logic [`DFC_NUM_G1-1:0] gen1;
	} dfc_src_s;

	typedef struct packed {
		logic busy;
		logic badsel;
		logic overrun;
		logic wake;
		logic drain;
		logic sleeping;
	} dfc_status_s;

endpackage

// >>> verilog/dfc_pulse_mux.sv
`timescale 1ns/1ps
`include "dfc_cfg.svh"

module dfc_pulse_mux
	import dfc_pkg::*;
(
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_rst,
	// Sources and selector
	input wire dfc_src_s i_src,
	input wire logic [`DFC_SEL_W-1:0] i_sel,
	// Selected frame start
	output logic o_pulse,
	output logic o_sel_valid
);

	logic [`DFC_NUM_ASYNC-1:0] async_in;
	logic [`DFC_NUM_ASYNC-1:0] meta_q, meta_d;
	logic [`DFC_NUM_ASYNC-1:0] sync_q, sync_d;
	logic [`DFC_NUM_ASYNC-1:0] last_q, last_d;
	logic [`DFC_NUM_ASYNC-1:0] rise;
	logic pulse_q, pulse_d;
	logic [`DFC_SEL_W-1:0] g2_idx;
	logic [`DFC_SEL_W-1:0] as_idx;

	assign async_in = {i_src.spdif, i_src.ser_out, i_src.ser_in};
	assign g2_idx = i_sel - `DFC_SEL_G2_DIV6;
	assign as_idx = i_sel - `DFC_SEL_SIN0;

	////////////////////////////////////////////////////////////////////////
	// Frame clocks from pins are foreign: two stages, then a rising edge
	genvar g;
	generate
		for (g = 0; g < `DFC_NUM_ASYNC; g++) begin : g_edge
			assign rise[g] = sync_q[g] & ~last_q[g];
		end
	endgenerate

	always_comb begin
		meta_d = async_in;
		sync_d = meta_q;
		last_d = sync_q;
	end

	////////////////////////////////////////////////////////////////////////
	always_comb begin
		pulse_d = 1'b0;
		o_sel_valid = 1'b1;
		if (i_sel <= `DFC_SEL_G1_X4) begin
			pulse_d = i_src.gen1[i_sel[2:0]];
		end else if (i_sel <= `DFC_SEL_G2_X2D3) begin
			pulse_d = i_src.gen2[g2_idx[1:0]];
		end else if (i_sel <= `DFC_SEL_SPDIF) begin
			pulse_d = rise[as_idx[3:0]];
		end else begin
			o_sel_valid = 1'b0;
		end
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			meta_q <= '0;
			sync_q <= '0;
			last_q <= '0;
			pulse_q <= 1'b0;
		end else begin
			meta_q <= meta_d;
			sync_q <= sync_d;
			last_q <= last_d;
			pulse_q <= pulse_d;
		end
	end

	assign o_pulse = pulse_q;

endmodule

// >>> verilog/dfc_frame_control.sv
// Function
// - Finish current sample or block before sleeping
// - Sleep masks every core interrupt, except in the first sleeping cycle after a drain ended by i_block_end
// - No audio moves while sleeping; o_audio_en stays high for the first cycle that o_sleeping is high after a drain
// - Sleep bit resets zero; one requests sleep
// - Five-bit field selects frame start pulse
// - Selector resets to base rate code
// - Codes 0-4 pick first generator ratios
// - Codes 5-7 pick second generator ratios
// - Codes 8-11 follow serial input ports
// - Codes 12-15 follow serial output ports
// - Code 16 follows receiver recovered rate
//
// The implementer's own choice: the plain strobed port.
`timescale 1ns/1ps
`include "dfc_cfg.svh"

module dfc_frame_control
	import dfc_pkg::*;
(
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_rst,
	// Register port
	input wire logic [`DFC_ADDR_W-1:0] i_addr,
	input wire logic [`DFC_DATA_W-1:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [`DFC_DATA_W-1:0] o_rdata,
	// Frame pulse sources
	input wire dfc_src_s i_src,
	// Core handshake
	input wire logic i_proc_busy,
	input wire logic i_block_mode,
	input wire logic i_block_end,
	// Interrupts into the core
	input wire logic [`DFC_NUM_IRQ-1:0] i_irq,
	output logic [`DFC_NUM_IRQ-1:0] o_irq_core,
	// Core control
	output logic o_frame_start,
	output logic o_audio_en,
	output logic o_irq_mask,
	output logic o_sleeping,
	output logic [`DFC_SEL_W-1:0] o_rate_sel
);

	////////////////////////////////////////////////////////////////////////
	// Declarations
	logic sleep_q, sleep_d;
	logic [`DFC_SEL_W-1:0] sel_q, sel_d;
	dfc_core_state_e state_q, state_d;
	logic sleeping_q, sleeping_d;
	logic block_done_q, block_done_d;
	logic overrun_q, overrun_d;
	logic [`DFC_FCOUNT_W-1:0] fcount_q, fcount_d;
	logic fs_q, fs_d;
	logic mask_q, mask_d;
	logic audio_q, audio_d;
	logic [`DFC_NUM_IRQ-1:0] irq_q, irq_d;
	logic [`DFC_DATA_W-1:0] rdata_q, rdata_d;
	logic sel_pulse;
	logic sel_valid;
	logic wr_sleep;
	logic wr_fsel;
	logic wr_status;
	logic wr_fcount;
	logic drain_done;
	logic overrun_set;
	dfc_status_s status;

	////////////////////////////////////////////////////////////////////////
	// Frame pulse source selection
	dfc_pulse_mux u_mux (
		.i_clk(i_clk),
		.i_rst(i_rst),
		.i_src(i_src),
		.i_sel(sel_q),
		.o_pulse(sel_pulse),
		.o_sel_valid(sel_valid)
	);

	////////////////////////////////////////////////////////////////////////
	// Register writes
	assign wr_sleep = i_wr && (i_addr == `DFC_OFS_SLEEP);
	assign wr_fsel = i_wr && (i_addr == `DFC_OFS_FSEL);
	assign wr_status = i_wr && (i_addr == `DFC_OFS_STATUS);
	assign wr_fcount = i_wr && (i_addr == `DFC_OFS_FCOUNT);

	// Reserved bits are not stored, so they always read back as zero
	always_comb begin
		sleep_d = sleep_q;
		if (wr_sleep) begin
			sleep_d = i_wdata[`DFC_BIT_SLEEP];
		end
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			sleep_q <= `DFC_RST_SLEEP;
		end else begin
			sleep_q <= sleep_d;
		end
	end

	// Changing source mid-frame can give one short frame; change it while the core sleeps
	always_comb begin
		sel_d = sel_q;
		if (wr_fsel) begin
			sel_d = i_wdata[`DFC_SEL_W-1:0];
		end
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			sel_q <= `DFC_RST_FSEL;
		end else begin
			sel_q <= sel_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Core sleep sequencer
	// Sample flows drain once the core goes idle; block flows also need the block boundary
	assign drain_done = !i_proc_busy && (!i_block_mode || block_done_q || i_block_end);

	always_comb begin
		state_d = state_q;
		unique case (state_q)
			ST_RUN: begin
				if (sleep_q) begin
					state_d = ST_DRAIN;
				end
			end
			ST_DRAIN: begin
				if (!sleep_q) begin
					state_d = ST_RUN;
				end else if (drain_done) begin
					state_d = ST_SLEEP;
				end
			end
			ST_SLEEP: begin
				if (!sleep_q) begin
					state_d = ST_WAKE;
				end
			end
			ST_WAKE: begin
				if (sleep_q) begin
					state_d = ST_SLEEP;
				end else if (sel_pulse) begin
					state_d = ST_RUN;
				end
			end
		endcase
		sleeping_d = (state_d == ST_SLEEP);
	end

	// Sleeping is registered beside the state so the output never shows decode glitches
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			state_q <= ST_RUN;
			sleeping_q <= 1'b0;
		end else begin
			state_q <= state_d;
			sleeping_q <= sleeping_d;
		end
	end

	// Tracks a block boundary seen while draining
	always_comb begin
		block_done_d = block_done_q;
		if (state_q != ST_DRAIN) begin
			block_done_d = 1'b0;
		end else if (i_block_end) begin
			block_done_d = 1'b1;
		end
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			block_done_q <= 1'b0;
		end else begin
			block_done_q <= block_done_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Core control outputs
	always_comb begin
		fs_d = 1'b0;
		mask_d = 1'b0;
		audio_d = 1'b1;
		unique case (state_q)
			ST_RUN: begin
				fs_d = sel_pulse;
			end
			ST_DRAIN: begin
				// A block in progress still needs frames to reach its end
				fs_d = sel_pulse && i_block_mode && !block_done_q;
				mask_d = !i_block_mode || block_done_q;
			end
			ST_SLEEP: begin
				mask_d = 1'b1;
				audio_d = 1'b0;
			end
			ST_WAKE: begin
				// Resuming mid-frame would hand the core a partial sample
				fs_d = sel_pulse && !sleep_q;
				mask_d = !fs_d;
				audio_d = fs_d;
			end
		endcase
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			fs_q <= 1'b0;
			mask_q <= 1'b0;
			audio_q <= 1'b1;
		end else begin
			fs_q <= fs_d;
			mask_q <= mask_d;
			audio_q <= audio_d;
		end
	end

	// Gated by the next mask value so no interrupt slips past the mask edge
	always_comb begin
		irq_d = i_irq;
		if (mask_d) begin
			irq_d = '0;
		end
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			irq_q <= '0;
		end else begin
			irq_q <= irq_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Frame counter and missed-frame flag
	// A frame arriving while a sample is still in flight means it will be skipped
	assign overrun_set = fs_d && i_proc_busy && !i_block_mode;

	always_comb begin
		overrun_d = overrun_q;
		if (wr_status && i_wdata[`DFC_ST_OVERRUN]) begin
			overrun_d = 1'b0;
		end
		// Set wins over a clear in the same cycle
		if (overrun_set) begin
			overrun_d = 1'b1;
		end
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			overrun_q <= 1'b0;
		end else begin
			overrun_q <= overrun_d;
		end
	end

	// The counter wraps silently; software reads it twice to measure a rate
	always_comb begin
		fcount_d = fcount_q;
		if (wr_fcount) begin
			fcount_d = '0;
		end
		if (fs_d) begin
			fcount_d = fcount_d + `DFC_FCOUNT_W'(1);
		end
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			fcount_q <= '0;
		end else begin
			fcount_q <= fcount_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Register reads
	always_comb begin
		status = '0;
		status.sleeping = (state_q == ST_SLEEP);
		status.drain = (state_q == ST_DRAIN);
		status.wake = (state_q == ST_WAKE);
		status.overrun = overrun_q;
		// An unlisted selector code gives no frame pulse at all
		status.badsel = !sel_valid;
		status.busy = i_proc_busy;
	end

	always_comb begin
		rdata_d = '0;
		if (i_rd) begin
			unique case (i_addr)
				`DFC_OFS_SLEEP: begin
					rdata_d = `DFC_DATA_W'(sleep_q);
				end
				`DFC_OFS_FSEL: begin
					rdata_d = `DFC_DATA_W'(sel_q);
				end
				`DFC_OFS_STATUS: begin
					rdata_d = `DFC_DATA_W'(status);
				end
				`DFC_OFS_FCOUNT: begin
					rdata_d = fcount_q;
				end
				default: begin
					rdata_d = '0;
				end
			endcase
		end
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			rdata_q <= '0;
		end else begin
			rdata_q <= rdata_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Outputs
	assign o_rdata = rdata_q;
	assign o_frame_start = fs_q;
	assign o_audio_en = audio_q;
	assign o_irq_mask = mask_q;
	assign o_irq_core = irq_q;
	assign o_sleeping = sleeping_q;
	assign o_rate_sel = sel_q;

endmodule

// >>> tb/dfc_checker_assertions.sv
`timescale 1ns/1ps
`include "dfc_cfg.svh"
module dfc_checker
	import dfc_pkg::*;
(
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_rst,
	// Register port
	input wire logic [15:0] i_addr,
	input wire logic [15:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	input wire logic [15:0] o_rdata,
	// Core side
	input wire dfc_src_s i_src,
	input wire logic [7:0] i_irq,
	input wire logic [7:0] o_irq_core,
	input wire logic o_frame_start,
	input wire logic o_audio_en,
	input wire logic o_irq_mask,
	input wire logic o_sleeping,
	input wire logic [4:0] o_rate_sel
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_rst);
	a_reset_vals: assert property ($fell(i_rst) |-> o_rate_sel == 5'h02 && !o_sleeping)
		else $error("bad reset values");
	a_sleep_mask: assert property (o_sleeping && $past(o_sleeping) |-> o_irq_mask)
		else $error("sleep without mask");
	a_sleep_audio: assert property (o_sleeping && $past(o_sleeping) |-> !o_audio_en && !o_frame_start)
		else $error("audio while sleeping");
	a_irq_blocked: assert property ($past(o_irq_mask) && o_irq_mask |-> o_irq_core == 8'h00)
		else $error("masked irq passed");
	// Both mask samples low, so either gating stage passes the interrupt
	a_irq_pass: assert property (!$past(i_rst) && !$past(o_irq_mask) && !o_irq_mask |-> o_irq_core == $past(i_irq))
		else $error("irq not passed");
	a_sel_write: assert property (i_wr && i_addr == `DFC_OFS_FSEL |=> o_rate_sel == $past(i_wdata[4:0]))
		else $error("selector not written");
	a_sel_read: assert property (i_rd && i_addr == `DFC_OFS_FSEL |=> o_rdata == {11'h000, $past(o_rate_sel)})
		else $error("selector read wrong");
	a_sleep_read: assert property (i_rd && i_addr == `DFC_OFS_SLEEP |=> o_rdata[15:1] == 15'h0000)
		else $error("sleep reserved bits");
	a_rdata_idle: assert property (!$past(i_rd) |-> o_rdata == 16'h0000)
		else $error("read data not idle");
	a_frame_gen: assert property (i_src.gen1[2] && o_rate_sel == 5'h02 && !o_irq_mask ##2 !o_irq_mask |-> o_frame_start)
		else $error("frame pulse missing");
	c_sleep: cover property ($rose(o_sleeping));
	c_wake: cover property ($fell(o_sleeping));
	c_spdif: cover property (o_frame_start && o_rate_sel == 5'h10);
endmodule
bind dfc_frame_control dfc_checker dfc_checker_i (.i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata),
	.i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_src(i_src), .i_irq(i_irq), .o_irq_core(o_irq_core),
	.o_frame_start(o_frame_start), .o_audio_en(o_audio_en), .o_irq_mask(o_irq_mask), .o_sleeping(o_sleeping),
	.o_rate_sel(o_rate_sel));

// >>> tb/dfc_src_model.sv
`timescale 1ns/1ps
module dfc_src_model
	import dfc_pkg::*;
(
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_rst,
	// Source to run, numbered as the selector codes
	input wire logic [4:0] i_which,
	output dfc_src_s o_src
);
	logic [5:0] cnt_q;
	logic [5:0] cnt_d;
	always_comb begin
		cnt_d = (cnt_q == 6'h27) ? 6'h00 : cnt_q + 6'h01;
	end
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			cnt_q <= 6'h00;
		end else begin
			cnt_q <= cnt_d;
		end
	end
	// Only one source runs so a wrong selection shows as silence; idle frame clocks rest low
	always_comb begin
		o_src = '0;
		if (i_which < 5'h08) begin
			o_src[i_which] = (cnt_q == 6'h00);
		end else if (i_which <= 5'h10) begin
			o_src[i_which] = (cnt_q < 6'h14);
		end
	end
endmodule

// >>> tb/dfc_frame_control_bench.sv
`timescale 1ns/1ps
`include "dfc_cfg.svh"
module dfc_frame_control_bench
	import dfc_pkg::*;
;
	logic i_clk = 0, i_rst = 1, i_wr = 0, i_rd = 0, rd_q = 0;
	logic i_proc_busy = 0, i_block_mode = 0, i_block_end = 0;
	logic o_frame_start, o_audio_en, o_irq_mask, o_sleeping;
	logic [15:0] i_addr = '0, i_wdata = '0, o_rdata;
	logic [7:0] i_irq = '0, o_irq_core;
	logic [4:0] o_rate_sel, which = 5'h02;
	logic [15:0] exp_q[$];
	dfc_src_s i_src;
	int n_mismatch = 0, comparisons = 0, seed = 8, nf = 0;

	initial begin
		forever #2.5 i_clk = ~i_clk;
	end
	dfc_src_model dfc_src_model_i (.i_clk(i_clk), .i_rst(i_rst), .i_which(which), .o_src(i_src));
	dfc_frame_control dfc_frame_control_i (.i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata),
		.i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_src(i_src), .i_proc_busy(i_proc_busy),
		.i_block_mode(i_block_mode), .i_block_end(i_block_end), .i_irq(i_irq), .o_irq_core(o_irq_core),
		.o_frame_start(o_frame_start), .o_audio_en(o_audio_en), .o_irq_mask(o_irq_mask),
		.o_sleeping(o_sleeping), .o_rate_sel(o_rate_sel));

	////////////////////////////////////////////////////////////////////////////////
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wrap_up();
		$display("comparisons %0d n_mismatch %0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	// One idle cycle after each strobe keeps every signal to one change per step
	task automatic wr(input logic [15:0] a, input logic [15:0] d);
		i_wr <= 1'b1;
		i_addr <= a;
		i_wdata <= d;
		@(posedge i_clk);
		i_wr <= 1'b0;
		@(posedge i_clk);
	endtask
	task automatic rd(input logic [15:0] a, input logic [15:0] e);
		exp_q.push_back(e);
		i_rd <= 1'b1;
		i_addr <= a;
		@(posedge i_clk);
		i_rd <= 1'b0;
		@(posedge i_clk);
	endtask
	task automatic frames(input logic [4:0] w, input logic e);
		int n0;
		which <= w;
		repeat (20) @(posedge i_clk);
		n0 = nf;
		repeat (100) @(posedge i_clk);
		check({15'h0000, nf != n0}, {15'h0000, e});
	endtask

	////////////////////////////////////////////////////////////////////////////////
	always @(posedge i_clk) begin
		i_irq <= 8'($random(seed));
		rd_q <= i_rd;
		if (o_frame_start === 1'b1) begin
			nf <= nf + 1;
		end
		if (rd_q) begin
			check(o_rdata, exp_q.pop_front());
		end
	end
	initial begin
		repeat (20000) @(posedge i_clk);
		n_mismatch++;
		wrap_up();
	end
	initial begin
		repeat (10) @(posedge i_clk);
		i_rst <= 1'b0;
		@(posedge i_clk);
		rd(`DFC_OFS_FSEL, 16'h0002);
		rd(`DFC_OFS_SLEEP, 16'h0000);
		wr(16'hF4FF, 16'hFFFF);
		rd(16'hF4FF, 16'h0000);
		for (int c = 0; c < 18; c++) begin
			wr(`DFC_OFS_FSEL, 16'hFFE0 | 16'(c));
			rd(`DFC_OFS_FSEL, 16'(c) & 16'h001F);
			if (c == 17) begin
				rd(`DFC_OFS_STATUS, 16'h0010);
			end
			frames(c < 17 ? 5'(c) : 5'h02, c < 17);
			frames(5'((c + 1) % 17), 1'b0);
		end
		wr(`DFC_OFS_FSEL, 16'h0002);
		i_proc_busy <= 1'b1;
		wr(`DFC_OFS_SLEEP, 16'h0001);
		repeat (40) @(posedge i_clk);
		check({15'h0000, o_sleeping}, 16'h0000);
		i_proc_busy <= 1'b0;
		repeat (5) @(posedge i_clk);
		check({14'h0000, o_sleeping, o_audio_en}, 16'h0002);
		check({8'h00, o_irq_core}, 16'h0000);
		frames(5'h02, 1'b0);
		rd(`DFC_OFS_SLEEP, 16'h0001);
		wr(`DFC_OFS_STATUS, 16'h0008);
		rd(`DFC_OFS_STATUS, 16'h0001);
		wr(`DFC_OFS_FCOUNT, 16'h0000);
		rd(`DFC_OFS_FCOUNT, 16'h0000);
		wr(`DFC_OFS_SLEEP, 16'h0000);
		for (int k = 0; k < 100 && o_frame_start !== 1'b1; k++) begin
			@(posedge i_clk);
		end
		check({14'h0000, o_irq_mask, o_audio_en}, 16'h0001);
		rd(`DFC_OFS_FCOUNT, 16'h0001);
		@(posedge i_clk);
		i_block_mode <= 1'b1;
		wr(`DFC_OFS_SLEEP, 16'h0001);
		repeat (80) @(posedge i_clk);
		check({15'h0000, o_sleeping}, 16'h0000);
		i_block_end <= 1'b1;
		@(posedge i_clk);
		i_block_end <= 1'b0;
		repeat (5) @(posedge i_clk);
		check({15'h0000, o_sleeping}, 16'h0001);
		wrap_up();
	end
endmodule
